// file: sod_dict.sv
/*
 object dictionary of the encoder slave: answers mailbox reads and writes
 by index and subindex, and holds the input image builder.
 assumes the mailbox logic presents one request at a time with a strobe.
*/
// How it works
// - The input image opens with data fault, frame fault and power fail bits.
// - Ten zero padding bits follow the three leading status bits.
// - Then come cycle sync fault, position invalid and update toggle bits.
// - The image ends with the 32-bit position, giving eight mapping entries.
// - The serial word holds year in bits 0-7, week in bits 8-15, zero above.
// - The revision word has variant low and description revision high.
// - Four channel types 1 to 4 are reported in channel order.
// - A read-only 32-bit backup checksum is offered.
// - Identity reports four read-only entries: maker, part, revision, serial.
// - The output assignment holds one writable 16-bit entry reset to 0x1601.
// - The firmware version string is readable and never writable.
// - The update toggle inverts on every image refresh.
`timescale 1ns/10ps
`default_nettype none
module sod_dict #(
   parameter logic [31:0] MAKER_CODE = 32'h0000_00A5, // arbitrary value
   parameter logic [31:0] PART_CODE = 32'h0000_5A5A, // arbitrary value
   parameter int SWVER_CHARS = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // identity straps
   input wire logic [15:0] variant_i,
   input wire logic [15:0] desc_rev_i,
   input wire logic [7:0] prod_year_i,
   input wire logic [7:0] prod_week_i,
   input wire logic [31:0] checksum_i,
   input wire logic [8*SWVER_CHARS-1:0] swver_i,
   // encoder status
   input wire logic upd_i,
   input wire sod_pkg::sod_status_type stat_i,
   // mailbox request and answer
   input wire logic req_i,
   input wire sod_pkg::sod_req_type req_data_i,
   output logic ack_o,
   output sod_pkg::sod_rsp_type rsp_o,
   // cyclic image and output assignment
   output logic [sod_pkg::SOD_IMG_BITS-1:0] image_o,
   output logic [15:0] out_assign_o
);
   import sod_pkg::*;

   // the string word is 32 bits wide, so more than four characters cannot be served
   generate
      if (SWVER_CHARS < 1 || SWVER_CHARS > 4) begin : g_bad_chars
         $error("SWVER_CHARS must be 1 to 4");
      end
   endgenerate

   logic ack_r;
   sod_rsp_type rsp_r;
   logic [7:0] asg_cnt_r;
   logic [15:0] asg_r;
   logic [31:0] rd_nxt;
   logic found;
   logic writable;
   logic [7:0] smtype [4];
   logic toggle;
   logic [31:0] swver_word;

   sod_image u_image (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .upd_i(upd_i),
      .stat_i(stat_i),
      .image_o(image_o),
      .toggle_o(toggle)
   );

   // channel types equal the channel number
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sm
         assign smtype[g] = 8'(g + 1);
      end
   endgenerate

   assign swver_word = 32'(swver_i);

   function automatic logic [31:0] map_entry(input logic [7:0] sub, input logic [7:0] len);
      map_entry = {SOD_IDX_INPUTS, sub, len};
   endfunction

   always_comb begin
      rd_nxt = 32'h0000_0000;
      found = 1'b1;
      writable = 1'b0;
      case (req_data_i.index)
         SOD_IDX_SWVER: begin
            if (req_data_i.sub == 8'h00) begin
               rd_nxt = swver_word;
            end else begin
               found = 1'b0;
            end
         end
         SOD_IDX_IDENT: begin
            case (req_data_i.sub)
               8'h00: rd_nxt = 32'(SOD_IDENT_CNT);
               8'h01: rd_nxt = MAKER_CODE;
               8'h02: rd_nxt = PART_CODE;
               8'h03: rd_nxt = {desc_rev_i, variant_i};
               8'h04: rd_nxt = {16'h0000, prod_week_i, prod_year_i};
               default: found = 1'b0;
            endcase
         end
         SOD_IDX_BACKUP: begin
            case (req_data_i.sub)
               8'h00: rd_nxt = 32'(SOD_BACKUP_CNT);
               8'h01: rd_nxt = checksum_i;
               default: found = 1'b0;
            endcase
         end
         SOD_IDX_INMAP: begin
            case (req_data_i.sub)
               8'h00: rd_nxt = 32'(SOD_INMAP_CNT);
               8'h01: rd_nxt = map_entry(SOD_SUB_DATA_FLT, 8'h01);
               8'h02: rd_nxt = map_entry(SOD_SUB_FRAME_FLT, 8'h01);
               8'h03: rd_nxt = map_entry(SOD_SUB_PWR_FAIL, 8'h01);
               8'h04: rd_nxt = {24'h000000, 8'(SOD_PAD_BITS)};
               8'h05: rd_nxt = map_entry(SOD_SUB_SYNC_FLT, 8'h01);
               8'h06: rd_nxt = map_entry(SOD_SUB_VALID, 8'h01);
               8'h07: rd_nxt = map_entry(SOD_SUB_TOGGLE, 8'h01);
               8'h08: rd_nxt = map_entry(SOD_SUB_POS, 8'(SOD_POS_BITS));
               default: found = 1'b0;
            endcase
         end
         SOD_IDX_SMTYPE: begin
            if (req_data_i.sub == 8'h00) begin
               rd_nxt = 32'(SOD_SMTYPE_CNT);
            end else if (req_data_i.sub <= 8'h04) begin
               rd_nxt = 32'(smtype[2'(req_data_i.sub - 8'h01)]);
            end else begin
               found = 1'b0;
            end
         end
         SOD_IDX_OUTASG: begin
            writable = 1'b1;
            case (req_data_i.sub)
               8'h00: rd_nxt = 32'(asg_cnt_r);
               8'h01: rd_nxt = 32'(asg_r);
               default: begin
                  found = 1'b0;
                  writable = 1'b0;
               end
            endcase
         end
         SOD_IDX_INPUTS: begin
            case (req_data_i.sub)
               SOD_SUB_DATA_FLT: rd_nxt = 32'(image_o[0]);
               SOD_SUB_FRAME_FLT: rd_nxt = 32'(image_o[1]);
               SOD_SUB_PWR_FAIL: rd_nxt = 32'(image_o[2]);
               SOD_SUB_SYNC_FLT: rd_nxt = 32'(image_o[13]);
               SOD_SUB_VALID: rd_nxt = 32'(image_o[14]);
               SOD_SUB_TOGGLE: rd_nxt = 32'(toggle);
               SOD_SUB_POS: rd_nxt = image_o[47:16];
               default: found = 1'b0;
            endcase
         end
         default: found = 1'b0;
      endcase
   end

   // only the output assignment accepts writes
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         asg_cnt_r <= SOD_OUTASG_CNT_RST;
         asg_r <= SOD_OUTASG_RST;
      end else if (ce_i && req_i && req_data_i.wr && found && writable) begin
         if (req_data_i.sub == 8'h00) begin
            asg_cnt_r <= req_data_i.wdata[7:0];
         end else begin
            asg_r <= req_data_i.wdata[15:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
         rsp_r <= '0;
      end else if (ce_i) begin
         ack_r <= req_i;
         if (req_i) begin
            rsp_r.rdata <= rd_nxt;
            if (!found) begin
               rsp_r.status <= SOD_ST_NOOBJ;
            end else if (req_data_i.wr && !writable) begin
               rsp_r.status <= SOD_ST_RDONLY;
            end else begin
               rsp_r.status <= SOD_ST_OK;
            end
         end
      end
   end

   assign ack_o = ack_r;
   assign rsp_o = rsp_r;
   assign out_assign_o = asg_r;

   AST_RO_REFUSED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.wr && req_data_i.index != SOD_IDX_OUTASG)
      |=> (rsp_r.status != SOD_ST_OK && $stable(asg_r)))
      else $error("read-only write was not refused");
   AST_ASG_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.wr && req_data_i.index == SOD_IDX_OUTASG
       && req_data_i.sub == 8'h01) |=> (asg_r == $past(req_data_i.wdata[15:0])))
      else $error("output assignment write lost");
   AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i) |=> ack_r)
      else $error("request not answered next cycle");
   AST_SERIAL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.index == SOD_IDX_IDENT && req_data_i.sub == 8'h04)
      |=> (rsp_r.rdata[31:16] == 16'h0000
           && rsp_r.rdata[7:0] == $past(prod_year_i)))
      else $error("serial word layout wrong");
   AST_REVISION: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.index == SOD_IDX_IDENT && req_data_i.sub == 8'h03)
      |=> (rsp_r.rdata == {$past(desc_rev_i), $past(variant_i)}))
      else $error("revision word layout wrong");
   AST_SMTYPE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.index == SOD_IDX_SMTYPE && req_data_i.sub == 8'h03)
      |=> (rsp_r.rdata == 32'h0000_0003))
      else $error("channel type wrong");
   AST_CHECKSUM: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.index == SOD_IDX_BACKUP && req_data_i.sub == 8'h01)
      |=> (rsp_r.rdata == $past(checksum_i)))
      else $error("checksum read wrong");
   AST_IDENT_CNT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && !req_data_i.wr && req_data_i.index == SOD_IDX_IDENT
       && req_data_i.sub == 8'h00) |=> (rsp_r.rdata == 32'h0000_0004))
      else $error("identity count wrong");
   AST_SWVER_RO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && req_i && req_data_i.wr && req_data_i.index == SOD_IDX_SWVER
       && req_data_i.sub == 8'h00) |=> (rsp_r.status == SOD_ST_RDONLY))
      else $error("firmware string write accepted");
   COV_RO_WRITE: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      ack_r && rsp_r.status == SOD_ST_RDONLY);
   COV_ASG_WRITE: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      ce_i && req_i && req_data_i.wr && req_data_i.index == SOD_IDX_OUTASG);
   COV_NOOBJ: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      ack_r && rsp_r.status == SOD_ST_NOOBJ);
endmodule
`default_nettype wire

// file: sod_pkg.sv
/*
 object dictionary constants, field layouts and carrier structs for the
 encoder slave. assumes nothing of its surroundings.
*/
package sod_pkg;
   // object indices
   localparam logic [15:0] SOD_IDX_SWVER = 16'h100A;
   localparam logic [15:0] SOD_IDX_IDENT = 16'h1018;
   localparam logic [15:0] SOD_IDX_BACKUP = 16'h10F0;
   localparam logic [15:0] SOD_IDX_INMAP = 16'h1A00;
   localparam logic [15:0] SOD_IDX_SMTYPE = 16'h1C00;
   localparam logic [15:0] SOD_IDX_OUTASG = 16'h1C12;
   localparam logic [15:0] SOD_IDX_INPUTS = 16'h6000;
   // entry counts and output assignment reset entry
   localparam logic [7:0] SOD_IDENT_CNT = 8'h04;
   localparam logic [7:0] SOD_BACKUP_CNT = 8'h01;
   localparam logic [7:0] SOD_INMAP_CNT = 8'h08;
   localparam logic [7:0] SOD_SMTYPE_CNT = 8'h04;
   localparam logic [7:0] SOD_OUTASG_CNT_RST = 8'h01;
   localparam logic [15:0] SOD_OUTASG_RST = 16'h1601;
   // input image field widths and layout
   localparam int SOD_PAD_BITS = 10;
   localparam int SOD_POS_BITS = 32;
   localparam int SOD_IMG_BITS = 3 + SOD_PAD_BITS + 3 + SOD_POS_BITS;
   localparam logic [7:0] SOD_SUB_DATA_FLT = 8'h01;
   localparam logic [7:0] SOD_SUB_FRAME_FLT = 8'h02;
   localparam logic [7:0] SOD_SUB_PWR_FAIL = 8'h03;
   localparam logic [7:0] SOD_SUB_SYNC_FLT = 8'h0E;
   localparam logic [7:0] SOD_SUB_VALID = 8'h0F;
   localparam logic [7:0] SOD_SUB_TOGGLE = 8'h10;
   localparam logic [7:0] SOD_SUB_POS = 8'h11;
   // serial word fields
   localparam int SOD_SER_YEAR_LSB = 0;
   localparam int SOD_SER_WEEK_LSB = 8;
   // answer status: ok and abort codes
   localparam logic [1:0] SOD_ST_OK = 2'h0;
   localparam logic [1:0] SOD_ST_RDONLY = 2'h1;
   localparam logic [1:0] SOD_ST_NOOBJ = 2'h2;

   typedef struct packed {
      logic data_fault;
      logic frame_fault;
      logic power_fail;
      logic cycle_sync_fault;
      logic position_invalid;
      logic [31:0] position;
   } sod_status_type;

   typedef struct packed {
      logic [15:0] index;
      logic [7:0] sub;
      logic wr;
      logic [31:0] wdata;
   } sod_req_type;

   typedef struct packed {
      logic [1:0] status;
      logic [31:0] rdata;
   } sod_rsp_type;
endpackage

// file: sod_image.sv
/*
 builds the cyclic input process image and its update toggle.
 assumes the status arrives synchronous to mclk_i with a one-cycle strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module sod_image (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // fresh status
   input wire logic upd_i,
   input wire sod_pkg::sod_status_type stat_i,
   // image out
   output logic [sod_pkg::SOD_IMG_BITS-1:0] image_o,
   output logic toggle_o
);
   import sod_pkg::*;
   logic toggle_r;
   logic [SOD_IMG_BITS-1:0] image_r;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         toggle_r <= 1'b0;
      end else if (ce_i && upd_i) begin
         toggle_r <= ~toggle_r;
      end
   end

   // image bit 0 is the first field on the wire
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         image_r <= '0;
      end else if (ce_i && upd_i) begin
         image_r <= {stat_i.position,
                     ~toggle_r, stat_i.position_invalid, stat_i.cycle_sync_fault,
                     {SOD_PAD_BITS{1'b0}},
                     stat_i.power_fail, stat_i.frame_fault, stat_i.data_fault};
      end
   end

   assign image_o = image_r;
   assign toggle_o = toggle_r;

   AST_TOGGLE_FLIPS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && upd_i) |=> (toggle_r != $past(toggle_r)))
      else $error("toggle did not invert on update");
   AST_TOGGLE_IN_IMAGE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && upd_i) |=> (image_r[15] == toggle_r))
      else $error("image toggle bit differs from toggle");
   AST_PAD_ZERO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      image_r[12:3] == 10'h000)
      else $error("padding bits not zero");
   AST_POS_FIELD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && upd_i) |=> (image_r[47:16] == $past(stat_i.position)))
      else $error("position field wrong");
   AST_LEAD_BITS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && upd_i) |=> (image_r[0] == $past(stat_i.data_fault)
                           && image_r[1] == $past(stat_i.frame_fault)
                           && image_r[2] == $past(stat_i.power_fail)))
      else $error("leading status bits wrong");
   COV_UPDATE: cover property (@(posedge mclk_i) disable iff (!rstn_i) ce_i && upd_i);
endmodule
`default_nettype wire

// file: sod_master.sv
/*
 fieldbus master model: issues mailbox reads and writes to the dictionary.
 assumes the bench drives mclk_i and calls xfer one transfer at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module sod_master (
   // clock
   input wire logic mclk_i,
   // mailbox
   output logic req_o,
   output sod_pkg::sod_req_type req_data_o,
   input wire logic ack_i,
   input wire sod_pkg::sod_rsp_type rsp_i
);
   import sod_pkg::*;
   logic timed_out;
   initial begin
      req_o = 1'b0;
      req_data_o = '0;
      timed_out = 1'b0;
   end
   task automatic xfer(input logic [15:0] idx, input logic [7:0] sub, input logic wr,
      input logic [31:0] wdata, output sod_rsp_type rsp);
      int n;
      @(negedge mclk_i);
      req_o = 1'b1;
      req_data_o = '{index: idx, sub: sub, wr: wr, wdata: wdata};
      @(negedge mclk_i);
      req_o = 1'b0;
      // released fields turn to garbage so a late sample shows up
      req_data_o = ~req_data_o;
      n = 0;
      while (ack_i !== 1'b1 && n < 4) begin
         @(negedge mclk_i);
         n++;
      end
      if (ack_i !== 1'b1) timed_out = 1'b1;
      rsp = rsp_i;
   endtask
endmodule
`default_nettype wire

// file: sod_dict_bench.sv
/*
 self-checking bench for the object dictionary: mailbox reads and writes
 through the master model, image refreshes from a stub encoder.
 assumes the design answers one cycle after each request.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module sod_dict_bench;
   import sod_pkg::*;
   localparam logic [31:0] MAKER = 32'h0000_00C3; // arbitrary value
   localparam logic [31:0] PART = 32'h0000_3C3C; // arbitrary value
   logic mclk_i, rstn_i, ce_i, upd_i, req_i, ack_o, tog;
   logic [15:0] variant_i, desc_rev_i, out_assign_o;
   logic [7:0] prod_year_i, prod_week_i;
   logic [31:0] checksum_i, swver_i;
   sod_status_type stat_i;
   sod_req_type req_data_i;
   sod_rsp_type rsp_o, r;
   logic [SOD_IMG_BITS-1:0] image_o, img_exp;
   logic [31:0] map_tab [0:8];
   int checks, miscompares;
   sod_dict #(.MAKER_CODE(MAKER), .PART_CODE(PART), .SWVER_CHARS(4)) DUT (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .variant_i(variant_i),
      .desc_rev_i(desc_rev_i), .prod_year_i(prod_year_i), .prod_week_i(prod_week_i),
      .checksum_i(checksum_i), .swver_i(swver_i), .upd_i(upd_i), .stat_i(stat_i),
      .req_i(req_i), .req_data_i(req_data_i), .ack_o(ack_o), .rsp_o(rsp_o),
      .image_o(image_o), .out_assign_o(out_assign_o));
   sod_master mst (
      .mclk_i(mclk_i), .req_o(req_i), .req_data_o(req_data_i), .ack_i(ack_o), .rsp_i(rsp_o));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // read, try a write of the inverse, read again: value must survive
   task automatic ro_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
      mst.xfer(idx, sub, 1'b0, 32'h0, r);
      `CHK("ro read status", SOD_ST_OK, r.status)
      `CHK("ro read data", e, r.rdata)
      mst.xfer(idx, sub, 1'b1, ~e, r);
      `CHK("ro write status", SOD_ST_RDONLY, r.status)
      mst.xfer(idx, sub, 1'b0, 32'h0, r);
      `CHK("ro data kept", e, r.rdata)
   endtask
   task automatic img(input sod_status_type s);
      @(negedge mclk_i);
      stat_i = s;
      upd_i = 1'b1;
      @(negedge mclk_i);
      upd_i = 1'b0;
      stat_i = ~s;
      tog = ~tog;
      img_exp = {s.position, tog, s.position_invalid, s.cycle_sync_fault, 10'h000,
         s.power_fail, s.frame_fault, s.data_fault};
      `CHK("image", img_exp, image_o)
   endtask
   initial begin
      #(5.0 * 3000);
      miscompares++;
      print_verdict();
   end
   initial begin
      rstn_i = 1'b0;
      ce_i = 1'b1;
      upd_i = 1'b0;
      stat_i = '0;
      variant_i = 16'h0B07;
      desc_rev_i = 16'h03E9;
      prod_year_i = 8'h19;
      prod_week_i = 8'h2A;
      checksum_i = 32'hC0DE_1234;
      swver_i = 32'h3130_3230;
      tog = 1'b0;
      checks = 0;
      miscompares = 0;
      map_tab = '{32'h0000_0008, 32'h6000_0101, 32'h6000_0201, 32'h6000_0301, 32'h0000_000A,
         32'h6000_0E01, 32'h6000_0F01, 32'h6000_1001, 32'h6000_1120};
      repeat (16) @(negedge mclk_i);
      rstn_i = 1'b1;
      `CHK("assign pin reset", SOD_OUTASG_RST, out_assign_o)
      mst.xfer(SOD_IDX_OUTASG, 8'h00, 1'b0, 32'h0, r);
      `CHK("assign count", 32'h1, r.rdata)
      mst.xfer(SOD_IDX_OUTASG, 8'h01, 1'b0, 32'h0, r);
      `CHK("assign entry", 32'h1601, r.rdata)
      ro_chk(SOD_IDX_IDENT, 8'h00, 32'h4);
      ro_chk(SOD_IDX_IDENT, 8'h01, MAKER);
      ro_chk(SOD_IDX_IDENT, 8'h02, PART);
      ro_chk(SOD_IDX_IDENT, 8'h03, 32'h03E9_0B07);
      ro_chk(SOD_IDX_IDENT, 8'h04, 32'h0000_2A19);
      ro_chk(SOD_IDX_BACKUP, 8'h00, 32'h1);
      ro_chk(SOD_IDX_BACKUP, 8'h01, 32'hC0DE_1234);
      ro_chk(SOD_IDX_SWVER, 8'h00, 32'h3130_3230);
      for (int i = 0; i < 9; i++) begin
         ro_chk(SOD_IDX_INMAP, i[7:0], map_tab[i]);
      end
      for (int i = 0; i < 5; i++) begin
         ro_chk(SOD_IDX_SMTYPE, i[7:0], (i == 0) ? 32'h4 : i);
      end
      mst.xfer(SOD_IDX_OUTASG, 8'h01, 1'b1, 32'hFFFF_1600, r);
      `CHK("assign write status", SOD_ST_OK, r.status)
      `CHK("assign pin", 16'h1600, out_assign_o)
      mst.xfer(SOD_IDX_OUTASG, 8'h01, 1'b0, 32'h0, r);
      `CHK("assign readback", 32'h1600, r.rdata)
      mst.xfer(SOD_IDX_OUTASG, 8'h00, 1'b1, 32'h0000_0000, r);
      `CHK("assign count write", SOD_ST_OK, r.status)
      mst.xfer(SOD_IDX_OUTASG, 8'h00, 1'b0, 32'h0, r);
      `CHK("assign count readback", 32'h0, r.rdata)
      mst.xfer(SOD_IDX_OUTASG, 8'h05, 1'b1, 32'h1, r);
      `CHK("bad sub status", SOD_ST_NOOBJ, r.status)
      `CHK("assign pin kept", 16'h1600, out_assign_o)
      mst.xfer(16'h2000, 8'h00, 1'b0, 32'h0, r);
      `CHK("no object status", SOD_ST_NOOBJ, r.status)
      img('{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 32'hA5A5_0F0F});
      img('{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 32'h8000_0001});
      ro_chk(SOD_IDX_INPUTS, SOD_SUB_SYNC_FLT, 32'h1);
      ro_chk(SOD_IDX_INPUTS, SOD_SUB_DATA_FLT, 32'h0);
      img('{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 32'hFFFF_FFFF});
      ro_chk(SOD_IDX_INPUTS, SOD_SUB_TOGGLE, {31'h0000_0000, tog});
      ro_chk(SOD_IDX_INPUTS, SOD_SUB_VALID, 32'h1);
      ro_chk(SOD_IDX_INPUTS, SOD_SUB_POS, 32'hFFFF_FFFF);
      // frozen clock enable: a refresh must not land
      @(negedge mclk_i);
      ce_i = 1'b0;
      upd_i = 1'b1;
      stat_i = '0;
      @(negedge mclk_i);
      upd_i = 1'b0;
      ce_i = 1'b1;
      `CHK("image frozen", img_exp, image_o)
      `CHK("ack timeout", 1'b0, mst.timed_out)
      print_verdict();
   end
endmodule
`default_nettype wire
